// >>> hdl/io_port_watchdog_pkg.sv
/*
  Package for the I/O-port watchdog: port address, interval limits, timing constants.
  Assumes a 10 MHz system clock and a 16-bit system I/O address space.
*/
package io_port_watchdog_pkg;
  localparam logic [15:0] WDT_PORT_ADDR     = 16'h0443;
  localparam logic [7:0]  INTERVAL_MIN      = 8'h01;
  localparam logic [7:0]  INTERVAL_MAX      = 8'h3e;
  localparam int          CLK_HZ            = 10000000;
  localparam int          SECOND_NS         = 1000000000;
  localparam int          CLK_PERIOD_NS     = 100;
  localparam int          CYCLES_PER_SECOND = SECOND_NS / CLK_PERIOD_NS;
  localparam int          RESET_PULSE_CYC   = 16;
  localparam logic [7:0]  READ_VALUE_RESET  = 8'h00;

  typedef struct packed {
    logic        wrStrobe;
    logic        rdStrobe;
    logic [15:0] addr;
    logic [7:0]  wrData;
  } io_req_t;
endpackage

// >>> hdl/io_port_watchdog_timer.sv
/*
  Watchdog timer reached through a single byte-wide I/O port.
  A write of a non-zero byte loads the interval in whole seconds and starts
  or restarts the countdown; a read returns the last interval and stops it.
  When the countdown runs out a reset pulse of fixed width is raised, after
  which the timer rests until the port is written again.
  Assumes one-cycle read and write strobes synchronous to clk, decoded I/O space,
  and a clock whose rate matches the seconds prescaler parameter.
*/
`timescale 1ns/10ps
`default_nettype none

module io_port_watchdog_timer #(
  parameter int SECOND_CYCLES = io_port_watchdog_pkg::CYCLES_PER_SECOND,
  parameter int PULSE_CYCLES  = io_port_watchdog_pkg::RESET_PULSE_CYC
) (
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  input  wire io_port_watchdog_pkg::io_req_t ioReq,
  output logic [7:0]                       rdData,
  output logic                             rdHit,
  output logic                             sysReset,
  output logic                             wdtActive
);
  // Counter widths follow the parameters so a short sim second still fits
  localparam int PW = $clog2(SECOND_CYCLES + 1);
  localparam int RW = $clog2(PULSE_CYCLES + 1);

  // Countdown phases
  typedef enum logic [1:0] {
    IDLE,
    RUN,
    FIRE
  } state_t;

  // Phase of the timer
  state_t        state_q;
  state_t        state_d;

  // Clock cycles within the current second
  logic [PW-1:0] prescale_q;
  logic [PW-1:0] prescale_d;

  // Whole seconds left before expiry
  logic [7:0]    seconds_q;
  logic [7:0]    seconds_d;

  // Last accepted interval, returned on a read
  logic [7:0]    interval_q;
  logic [7:0]    interval_d;

  // Cycles of the reset pulse already shown
  logic [RW-1:0] pulse_q;
  logic [RW-1:0] pulse_d;

  // Read data held for the host
  logic [7:0]    rdData_q;
  logic [7:0]    rdData_d;

  // Decoded accesses and timer events
  logic          wrHit;
  logic          rdAcc;
  logic          wrTake;
  logic          rdTake;
  logic          secondTick;
  logic          expire;
  logic          pulseDone;

  // Port address match, shared by both strobes
  function automatic logic portMatch(input logic [15:0] addr);
    portMatch = (addr == io_port_watchdog_pkg::WDT_PORT_ADDR);
  endfunction

  // Raw accesses that hit the port
  assign wrHit = portMatch(ioReq.addr) && ioReq.wrStrobe;
  assign rdAcc = portMatch(ioReq.addr) && ioReq.rdStrobe;

  // Accesses that take effect; the reset pulse is never cut short
  // Zero would expire at once; it is dropped rather than firing
  assign wrTake = wrHit && (ioReq.wrData != 8'h00) && (state_q != FIRE);
  assign rdTake = rdAcc && (state_q != FIRE);

  // Timer events
  assign secondTick = (state_q == RUN) && (prescale_q == PW'(SECOND_CYCLES - 1));
  assign expire     = secondTick && (seconds_q == 8'h01);
  assign pulseDone  = (state_q == FIRE) && (pulse_q == RW'(PULSE_CYCLES - 1));

  // Phase sequencing; a write wins over a read in the same cycle
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      IDLE, RUN: begin
        if (wrTake) begin
          state_d = RUN;
        end else if (rdTake) begin
          state_d = IDLE;
        end else if (expire) begin
          state_d = FIRE;
        end
      end
      FIRE: begin
        if (pulseDone) begin
          state_d = IDLE;
        end
      end
    endcase
  end

  // Phase register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Prescaler; a write restarts the second so refreshes are exact
  always_comb begin
    prescale_d = prescale_q;
    if (wrTake) begin
      prescale_d = '0;
    end else if (secondTick) begin
      prescale_d = '0;
    end else if (state_q == RUN) begin
      prescale_d = prescale_q + PW'(1);
    end
  end

  // Prescaler register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prescale_q <= '0;
    end else begin
      prescale_q <= prescale_d;
    end
  end

  // Seconds left; values above the documented range still count
  always_comb begin
    seconds_d = seconds_q;
    if (wrTake) begin
      seconds_d = ioReq.wrData;
    end else if (secondTick) begin
      seconds_d = seconds_q - 8'h01;
    end
  end

  // Seconds register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seconds_q <= '0;
    end else begin
      seconds_q <= seconds_d;
    end
  end

  // Interval kept only for the read-back value
  always_comb begin
    interval_d = interval_q;
    if (wrTake) begin
      interval_d = ioReq.wrData;
    end
  end

  // Interval register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      interval_q <= '0;
    end else begin
      interval_q <= interval_d;
    end
  end

  // Reset pulse width counter, cleared on entry to the pulse
  always_comb begin
    pulse_d = pulse_q;
    if (expire) begin
      pulse_d = '0;
    end else if ((state_q == FIRE) && !pulseDone) begin
      pulse_d = pulse_q + RW'(1);
    end
  end

  // Pulse register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pulse_q <= '0;
    end else begin
      pulse_q <= pulse_d;
    end
  end

  // Read returns last interval; mostly the read is a side effect
  always_comb begin
    rdData_d = rdData_q;
    if (rdTake) begin
      rdData_d = interval_q;
    end
  end

  // Read data register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData_q <= io_port_watchdog_pkg::READ_VALUE_RESET;
    end else begin
      rdData_q <= rdData_d;
    end
  end

  // Outputs; data straight from a flip-flop, status decoded from the phase register, read acknowledge from the address decode
  assign rdData    = rdData_q;
  assign rdHit     = rdAcc; // Decode acknowledge, combinational
  assign sysReset  = (state_q == FIRE);
  assign wdtActive = (state_q == RUN);
endmodule

`default_nettype wire

// >>> tb/io_port_watchdog_monitor.sv
/* Watchdog port checker.
   Assumes 10-cycle seconds and 4-cycle pulses. */
`timescale 1ns/10ps
`default_nettype none
module io_port_watchdog_monitor #(parameter int SECOND_CYCLES = 10, PULSE_CYCLES = 4) (
  input wire logic                          clk,
  input wire logic                          rst_n,
  input wire io_port_watchdog_pkg::io_req_t ioReq,
  input wire logic [7:0]                    rdData,
  input wire logic                          rdHit,
  input wire logic                          sysReset,
  input wire logic                          wdtActive
);
  logic hit, busy, wrOk, rdOk;
  // Taken accesses; zero data and pulse time refused
  assign hit = ioReq.addr == io_port_watchdog_pkg::WDT_PORT_ADDR && !sysReset;
  assign busy = hit && (ioReq.wrStrobe || ioReq.rdStrobe);
  assign wrOk = hit && ioReq.wrStrobe && ioReq.wrData != 8'h00;
  assign rdOk = hit && ioReq.rdStrobe && !ioReq.wrStrobe;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  start_a: assert property (wrOk |=> wdtActive) else $error("no start");
  refresh_a: assert property (wrOk |=> !sysReset [*8]) else $error("early end");
  stop_a: assert property (rdOk |=> !wdtActive) else $error("no stop");
  expire_a:
    assert property (wrOk && ioReq.wrData == 8'h01 ##1 !busy [*8] ##1 !busy |-> ##[1:2] sysReset)
    else $error("no expiry");
  pulse_a:
    assert property ($rose(sysReset) |-> sysReset [*4] ##1 !sysReset && !wdtActive) else $error("bad pulse");
  cover property (wrOk);
  cover property (rdOk);
  cover property ($rose(sysReset));
endmodule
bind io_port_watchdog_timer io_port_watchdog_monitor #(.SECOND_CYCLES(SECOND_CYCLES), .PULSE_CYCLES(PULSE_CYCLES))
  u_mon (.clk, .rst_n, .ioReq, .rdData, .rdHit, .sysReset, .wdtActive);
`default_nettype wire

// >>> tb/tb.sv
/* Watchdog bench.
   Assumes the timer and its checker compiled first. */
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk = 1'b0, rst_n = 1'b0, rdHit, sysReset, wdtActive;
  logic [7:0] rdData;
  io_port_watchdog_pkg::io_req_t ioReq = '0;
  int errors = 0, checked = 0;
  always #50 clk = ~clk;
  io_port_watchdog_timer #(.SECOND_CYCLES(10), .PULSE_CYCLES(4))
    u_dut (.clk, .rst_n, .ioReq, .rdData, .rdHit, .sysReset, .wdtActive);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %0t %h %h", $time, got, exp);
    end
  endtask
  // One-cycle access; 1 ns lets the taking edge settle
  task automatic io(input logic w, input logic r, input logic [7:0] d);
    @(posedge clk);
    ioReq <= '{w, r, io_port_watchdog_pkg::WDT_PORT_ADDR, d};
    #1 if (r) chk(8'(rdHit), 8'h01);
    @(posedge clk);
    ioReq <= '0;
    #1;
  endtask
  task automatic start_read();
    io(1'b1, 1'b0, 8'h3e);
    chk(8'(wdtActive), 8'h01);
    io(1'b0, 1'b1, 8'h00);
    chk(8'(wdtActive), 8'h00);
    chk(rdData, 8'h3e);
    io(1'b1, 1'b0, 8'h00);
    chk(8'(wdtActive), 8'h00);
  endtask
  // Top of the range: 62 seconds of 10 cycles each
  task automatic long_interval();
    io(1'b1, 1'b0, 8'h3e);
    repeat (618) @(posedge clk);
    #1 chk(8'(sysReset), 8'h00);
    repeat (2) @(posedge clk);
    #1 chk(8'(sysReset), 8'h01);
    repeat (6) @(posedge clk);
    chk(8'(wdtActive), 8'h00);
  endtask
  // Refresh inside the second, then let it lapse
  task automatic refresh_expire();
    repeat (3) begin
      io(1'b1, 1'b0, 8'h01);
      repeat (7) @(posedge clk);
      #1 chk(8'(sysReset), 8'h00);
    end
    repeat (4) @(posedge clk);
    #1 chk(8'(sysReset), 8'h01);
    io(1'b1, 1'b0, 8'h01);
    repeat (6) @(posedge clk);
    chk(8'(wdtActive), 8'h00);
    chk(8'(sysReset), 8'h00);
  endtask
  task automatic report_and_stop();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    start_read();
    refresh_expire();
    long_interval();
    report_and_stop();
  end
  // Hang guard: run needs about 700 cycles, allow over twice that
  initial begin
    #150000;
    errors++;
    report_and_stop();
  end
endmodule
`default_nettype wire
